/* rtl/spi_config_regs.vh */
// Register offsets, field positions, reset values and timing counts of the configuration bank
`ifndef SPI_CONFIG_REGS_VH
`define SPI_CONFIG_REGS_VH

// Register offsets on the serial port (byte addresses, 15-bit)
`define OFS_INTERFACE_CONFIG   15'h0000
`define OFS_DEVICE_OPER_CONFIG 15'h0002
`define OFS_MAKER_ID_LOW       15'h000c
`define OFS_MAKER_ID_HIGH      15'h000d
`define OFS_USER_SERIAL_CONFIG 15'h0010

// Field positions
`define BIT_SOFT_RESET         7
`define BIT_ASCEND             5
`define BIT_SEPARATE_OUTPUT    4
`define BIT_ADDR_HOLD          0
`define FLD_MODE_MSB           1
`define FLD_MODE_LSB           0

// Reset values
`define RST_INTERFACE_CONFIG   8'h30
`define RST_DEVICE_OPER_CONFIG 8'h00
`define RST_USER_SERIAL_CONFIG 8'h00

// Operating mode encodings
`define MODE_NORMAL            2'h0
`define MODE_POWER_DOWN        2'h3

// Timing: whole-chip reset window
`define CLK_PERIOD_NS          10
`define SOFT_RESET_NS          750
`define SOFT_RESET_CYCLES      7'h4b  // 750 ns at a 10 ns clock, sized for the window counter

// Serial frame: one direction bit plus a 15-bit address
`define HDR_LAST_BIT           4'hf

`endif

/* rtl/pin_synchronizer.v */
// Three-stage pin synchroniser with agreement filter, one stage set per bit
`timescale 1ns/1ps

module pin_synchronizer #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // Pins and filtered result
  input  wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] pinStable
);

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      reg stage1;
      reg stage2;
      reg stage3;
      reg stableBit;
      // Stage 1 feeds only stage 2; a change counts once stages 2 and 3 agree
      always @(posedge core_clk) begin
        if (rst) begin
          stage1    <= 1'b1;
          stage2    <= 1'b1;
          stage3    <= 1'b1;
          stableBit <= 1'b1;
        end else begin
          stage1 <= pinIn[i];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            stableBit <= stage3;
          end
        end
      end
      assign pinStable[i] = stableBit;
    end
  endgenerate

endmodule // pin_synchronizer

/* rtl/spi_config_register_bank.v */
// Serial-port configuration register bank with soft reset, streaming and identification
`timescale 1ns/1ps
`include "spi_config_regs.vh"

module spi_config_register_bank #(
  parameter [15:0] MAKER_CODE = 16'h5a3c  // Arbitrary value
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Serial host port pins
  input  wire       spiCsN,
  input  wire       spiSclk,
  input  wire       spiSdi,
  output reg        spiSdo,
  output reg        spiSdoEnN,
  // Configuration to the converter
  output reg        ascendMode,
  output reg        addrHold,
  output reg  [1:0] operatingMode,
  output reg        powerDown,
  output reg        chipReset
);

  localparam [6:0] RESET_CYCLES = `SOFT_RESET_CYCLES;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  wire [2:0] pinStable;
  wire       csNS;
  wire       sclkS;
  wire       sdiS;

  pin_synchronizer #(
    .WIDTH (3)
  ) uPins (
    .core_clk  (core_clk),
    .rst       (rst),
    .pinIn     ({spiCsN, spiSclk, spiSdi}),
    .pinStable (pinStable)
  );

  assign csNS  = pinStable[2];
  assign sclkS = pinStable[1];
  assign sdiS  = pinStable[0];

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg        sclkPrev;
  reg        hdrDone;
  reg        isRead;
  reg  [3:0] bitCnt;
  reg [14:0] hdrShift;
  reg [14:0] addr;
  reg  [6:0] dataShift;
  reg  [7:0] readShift;
  reg  [7:0] interfaceConfig;
  reg  [7:0] deviceOperConfig;
  reg  [7:0] userSerialConfig;
  reg        resetPending;
  reg  [6:0] resetCnt;

  wire       sclkRise;
  wire       sclkFall;
  wire [14:0] hdrAddr;
  wire [14:0] stepAddr;
  wire [7:0] wrByte;
  wire       softWrite;
  wire       resetActive;

  // Edge detection on the filtered serial clock, only inside a frame
  assign sclkRise = sclkS & ~sclkPrev & ~csNS;
  assign sclkFall = ~sclkS & sclkPrev & ~csNS;
  assign hdrAddr  = {hdrShift[13:0], sdiS};
  assign wrByte   = {dataShift, sdiS};

  // Next streaming address: hold, ascend or descend
  assign stepAddr = userSerialConfig[`BIT_ADDR_HOLD] ? addr :
                    interfaceConfig[`BIT_ASCEND] ? addr + 15'h0001 :
                    addr - 15'h0001;

  // Completed write of the soft reset bit in the interface register
  assign softWrite   = sclkRise & hdrDone & ~isRead & (bitCnt[2:0] == 3'h7) &
                       (addr == `OFS_INTERFACE_CONFIG) & wrByte[`BIT_SOFT_RESET];
  assign resetActive = resetCnt != 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux
  function [7:0] readReg;
    input [14:0] a;
    begin
      if (a == `OFS_INTERFACE_CONFIG) begin
        // Soft reset bit reads back clear; output-line flag always one
        readReg = {1'b0, interfaceConfig[6], interfaceConfig[5], 1'b1,
                   interfaceConfig[3:0]};
      end else if (a == `OFS_DEVICE_OPER_CONFIG) begin
        readReg = deviceOperConfig;
      end else if (a == `OFS_MAKER_ID_LOW) begin
        readReg = MAKER_CODE[7:0];
      end else if (a == `OFS_MAKER_ID_HIGH) begin
        readReg = MAKER_CODE[15:8];
      end else if (a == `OFS_USER_SERIAL_CONFIG) begin
        readReg = userSerialConfig;
      end else begin
        readReg = 8'h00;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine
  always @(posedge core_clk) begin
    if (rst || resetActive) begin
      sclkPrev  <= 1'b0;
      hdrDone   <= 1'b0;
      isRead    <= 1'b0;
      bitCnt    <= 4'h0;
      hdrShift  <= 15'h0000;
      addr      <= 15'h0000;
      dataShift <= 7'h00;
      readShift <= 8'h00;
      spiSdo    <= 1'b0;
      spiSdoEnN <= 1'b1;
    end else begin
      sclkPrev  <= sclkS;
      spiSdoEnN <= ~(~csNS & hdrDone & isRead);
      if (csNS) begin
        // Frame idle: rearm for the next header
        hdrDone <= 1'b0;
        bitCnt  <= 4'h0;
      end else if (sclkRise && !hdrDone) begin
        hdrShift <= hdrAddr;
        bitCnt   <= bitCnt + 4'h1;
        if (bitCnt == `HDR_LAST_BIT) begin
          hdrDone   <= 1'b1;
          isRead    <= hdrShift[14];
          addr      <= hdrAddr;
          readShift <= readReg(hdrAddr);
          bitCnt    <= 4'h0;
        end
      end else if (sclkRise) begin
        dataShift <= wrByte[6:0];
        bitCnt    <= {1'b0, bitCnt[2:0] + 3'h1};
        if (bitCnt[2:0] == 3'h7) begin
          addr <= stepAddr;
          if (isRead) begin
            readShift <= readReg(stepAddr);
          end
        end
      end else if (sclkFall && hdrDone && isRead) begin
        // Read data leaves MSB first on the separate output line
        spiSdo    <= readShift[7];
        readShift <= {readShift[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge core_clk) begin
    if (rst || resetActive) begin
      interfaceConfig  <= `RST_INTERFACE_CONFIG;
      deviceOperConfig <= `RST_DEVICE_OPER_CONFIG;
      userSerialConfig <= `RST_USER_SERIAL_CONFIG;
    end else if (sclkRise && hdrDone && !isRead && bitCnt[2:0] == 3'h7) begin
      if (addr == `OFS_INTERFACE_CONFIG) begin
        // Soft reset bit is not stored; flag bit stays one
        interfaceConfig <= {1'b0, wrByte[6:5], 1'b1, wrByte[3:0]};
      end else if (addr == `OFS_DEVICE_OPER_CONFIG) begin
        deviceOperConfig <= wrByte;
      end else if (addr == `OFS_USER_SERIAL_CONFIG) begin
        userSerialConfig <= wrByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset: armed by the write, fired at frame end, held for the window
  always @(posedge core_clk) begin
    if (rst) begin
      resetPending <= 1'b0;
      resetCnt     <= 7'h00;
      chipReset    <= 1'b0;
    end else begin
      if (softWrite) begin
        resetPending <= 1'b1;
      end else if (resetPending && csNS) begin
        resetPending <= 1'b0;
        resetCnt     <= RESET_CYCLES;
      end else if (resetActive) begin
        resetCnt <= resetCnt - 7'h01;
      end
      chipReset <= (resetPending && csNS && !softWrite) ||
                   (resetCnt > 7'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  always @(posedge core_clk) begin
    if (rst) begin
      ascendMode    <= 1'b1;
      addrHold      <= 1'b0;
      operatingMode <= `MODE_NORMAL;
      powerDown     <= 1'b0;
    end else begin
      ascendMode    <= interfaceConfig[`BIT_ASCEND];
      addrHold      <= userSerialConfig[`BIT_ADDR_HOLD];
      operatingMode <= deviceOperConfig[`FLD_MODE_MSB:`FLD_MODE_LSB];
      powerDown     <= deviceOperConfig[`FLD_MODE_MSB:`FLD_MODE_LSB]
                       == `MODE_POWER_DOWN;
    end
  end

endmodule // spi_config_register_bank

/* testbench/spi_config_props.sv */
// Assertion checker for the configuration register bank ports
`timescale 1ns/1ps
module spi_config_props (
  // Clock and reset
  input wire       core_clk,
  input wire       rst,
  // Serial pins
  input wire       spiCsN,
  input wire       spiSclk,
  input wire       spiSdi,
  input wire       spiSdo,
  input wire       spiSdoEnN,
  // Configuration outputs
  input wire       ascendMode,
  input wire       addrHold,
  input wire [1:0] operatingMode,
  input wire       powerDown,
  input wire       chipReset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Length of the current reset window
  reg [7:0] rstCnt;
  always @(posedge core_clk) begin
    rstCnt <= (chipReset && !rst) ? rstCnt + 8'h01 : 8'h00;
  end
  sequence csIdle; spiCsN [*6]; endsequence
  sequence resetStart; $rose(chipReset); endsequence
  a_power_down_on: assert property (
    operatingMode == 2'h3 |-> ##[0:1] powerDown) else $error("power down missing");
  a_power_down_off: assert property (
    operatingMode != 2'h3 && $past(operatingMode) != 2'h3 |-> !powerDown)
    else $error("power down without mode");
  a_reset_defaults: assert property (
    resetStart |-> ##[0:3] (ascendMode && !addrHold && operatingMode == 2'h0))
    else $error("config not reset");
  a_reset_after_frame: assert property (
    resetStart |-> spiCsN && $past(spiCsN)) else $error("reset inside frame");
  a_reset_window_len: assert property (
    $fell(chipReset) |-> rstCnt >= 8'h4a && rstCnt <= 8'h4c) else $error("reset window length");
  a_sdo_idle_off: assert property (
    csIdle |-> spiSdoEnN) else $error("output driven while idle");
  a_sdo_in_frame: assert property (
    !spiSdoEnN |-> !$past(spiCsN, 6)) else $error("output driven outside frame");
  a_sdo_on_fall: assert property (
    !spiSdoEnN && $changed(spiSdo) |-> !spiSclk) else $error("output moved on high clock");
endmodule // spi_config_props
bind spi_config_register_bank spi_config_props u_props (
  .core_clk(core_clk), .rst(rst), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdi(spiSdi),
  .spiSdo(spiSdo), .spiSdoEnN(spiSdoEnN), .ascendMode(ascendMode), .addrHold(addrHold),
  .operatingMode(operatingMode), .powerDown(powerDown), .chipReset(chipReset));

/* testbench/spi_host_model.sv */
// Serial host model that frames register reads and writes
`timescale 1ns/1ps
module spi_host_model (
  // Clock and read data
  input  wire core_clk,
  input  wire spiSdo,
  // Host pins
  output reg  spiCsN,
  output reg  spiSclk,
  output reg  spiSdi
);
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiSdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One frame: direction, address, then nb bytes; phases of 8 cycles
  task automatic frame(input logic rd, input logic [14:0] a, input int nb,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] sh;
    sh = {rd, a, wd};
    q = 16'h0000;
    @(negedge core_clk) spiCsN <= 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      spiSdi <= sh[31-i];
      repeat (8) @(negedge core_clk);
      spiSclk <= 1'b1;
      repeat (8) @(negedge core_clk);
      if (i >= 16) q = {q[14:0], spiSdo};
      spiSclk <= 1'b0;
    end
    repeat (8) @(negedge core_clk);
    spiCsN <= 1'b1;
    spiSdi <= ~spiSdi;
    if (!rd && a == 15'h0000 && wd[15]) repeat (90) @(negedge core_clk);
    repeat (8) @(negedge core_clk);
  endtask
endmodule // spi_host_model

/* testbench/testbench.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module testbench;
  localparam [15:0] MAKER = 16'hc3a5; // Arbitrary value
  // Clock, reset and pins
  reg         core_clk;
  reg         rst;
  wire        spiCsN, spiSclk, spiSdi, spiSdo, spiSdoEnN;
  wire        ascendMode, addrHold, powerDown, chipReset;
  wire [1:0]  operatingMode;
  // Counters and reference model
  integer     mismatches, nCompared, i;
  reg  [7:0]  ic, dc, uc;
  reg         sawReset;
  reg  [15:0] q;
  reg  [31:0] rb;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (rst) sawReset <= 1'b0;
    else if (chipReset === 1'b1) sawReset <= 1'b1;
  end
  spi_config_register_bank #(.MAKER_CODE(MAKER)) dut_u (.core_clk(core_clk), .rst(rst),
    .spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo),
    .spiSdoEnN(spiSdoEnN), .ascendMode(ascendMode), .addrHold(addrHold),
    .operatingMode(operatingMode), .powerDown(powerDown), .chipReset(chipReset));
  spi_host_model host_u (.core_clk(core_clk), .spiSdo(spiSdo), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiSdi(spiSdi));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared = nCompared + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Configuration outputs against the model
  task outs;
    chk({12'h000, ascendMode, addrHold, operatingMode}, {12'h000, ic[5], uc[0], dc[1:0]});
    chk({15'h0000, powerDown}, {15'h0000, dc[1:0] == 2'h3});
    chk({14'h0000, spiSdoEnN, chipReset}, 16'h0002);
  endtask
  // Single-byte write with model update
  task wr(input logic [14:0] a, input logic [7:0] b);
    host_u.frame(1'b0, a, 1, {b, 8'h00}, q);
    if (a == 15'h0000) ic = {1'b0, b[6:5], 1'b1, b[3:0]};
    if (a == 15'h0002) dc = b;
    if (a == 15'h0010) uc = b;
    if (a == 15'h0000 && b[7]) begin
      ic = 8'h30;
      dc = 8'h00;
      uc = 8'h00;
    end
  endtask
  // Read of nb bytes against an expected value
  task rd(input logic [14:0] a, input int nb, input logic [15:0] exp);
    host_u.frame(1'b1, a, nb, 16'h0000, q);
    chk(q, exp);
  endtask
  // Verdict and end of run
  task test_done;
    $display("Compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches = mismatches + 1;
    test_done;
  end
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    mismatches = 0;
    nCompared = 0;
    ic = 8'h30;
    dc = 8'h00;
    uc = 8'h00;
    rb = $urandom(32'h7ed9);
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (6) @(negedge core_clk);
    outs;
    rd(15'h0000, 1, 16'h0030);
    for (i = 0; i < 4; i++) begin
      wr(15'h0002, i[7:0]);
      outs;
      rd(15'h0002, 1, {8'h00, dc});
    end
    rb = $urandom;
    wr(15'h000c, rb[7:0]);
    rd(15'h000c, 2, {MAKER[7:0], MAKER[15:8]});
    wr(15'h0000, 8'h00);
    rd(15'h0000, 1, {8'h00, ic});
    outs;
    rd(15'h000d, 2, MAKER);
    wr(15'h0010, 8'h01);
    outs;
    rd(15'h0002, 2, {dc, dc});
    wr(15'h0000, 8'hb0);
    chk({15'h0000, sawReset}, 16'h0001);
    outs;
    rd(15'h0000, 1, 16'h0030);
    rd(15'h0010, 1, 16'h0000);
    test_done;
  end
endmodule // testbench
